// ---- logic/hlch_pkg.sv ----
package hlch_pkg;
    localparam logic [7:0] ADDR_DATA = 8'h00;
    localparam logic [7:0] ADDR_FEAT = 8'h04;
    localparam logic [7:0] ADDR_SCNT = 8'h08;
    localparam logic [7:0] ADDR_SNUM = 8'h0C;
    localparam logic [7:0] ADDR_CYLLO = 8'h10;
    localparam logic [7:0] ADDR_CYLHI = 8'h14;
    localparam logic [7:0] ADDR_CMD = 8'h18;
    localparam logic [7:0] ADDR_CTRL = 8'h1C;
    localparam logic [7:0] CMD_MONITOR = 8'hB0;
    localparam logic [7:0] SUB_READ_ATTR = 8'hD0;
    localparam logic [7:0] SUB_SAVE_ATTR = 8'hD3;
    localparam logic [7:0] SUB_READ_LOG = 8'hD5;
    localparam logic [7:0] SUB_WRITE_LOG = 8'hD6;
    localparam logic [7:0] SUB_ENABLE = 8'hD8;
    localparam logic [7:0] SUB_DISABLE = 8'hD9;
    localparam logic [7:0] SUB_STATUS = 8'hDA;
    localparam logic [7:0] SUB_AUTO_OFF = 8'hDB;
    localparam logic [7:0] LOG_DIR = 8'h00;
    localparam logic [7:0] LOG_SUMMARY = 8'h01;
    localparam logic [7:0] LOG_EXT_ERR = 8'h03;
    localparam logic [7:0] LOG_SELFTEST = 8'h06;
    localparam logic [7:0] LOG_EXT_SELFTEST = 8'h07;
    localparam logic [7:0] LOG_SELECTIVE = 8'h09;
    localparam logic [7:0] LOG_HOST_FIRST = 8'h80;
    localparam logic [7:0] LOG_HOST_LAST = 8'h9F;
    localparam logic [7:0] AUTO_OFF_DISABLE = 8'h00;
    localparam logic [7:0] AUTO_OFF_ENABLE = 8'hF8;
    localparam logic [7:0] GOOD_CYL_LO = 8'h4F;
    localparam logic [7:0] GOOD_CYL_HI = 8'hC2;
    localparam logic [7:0] BAD_CYL_LO = 8'hF4;
    localparam logic [7:0] BAD_CYL_HI = 8'h2C;
    localparam int ABORT_BIT = 2;
    localparam int WORDS = 128;
    localparam logic [6:0] LAST_WORD = 7'h7F;
    localparam logic [15:0] ATTR_REVISION = 16'h0010;
    localparam logic [8:0] OFF_OFFLINE_STATUS = 9'h16A;
    localparam logic [8:0] OFF_SELFTEST_STATUS = 9'h16B;
    localparam logic [8:0] OFF_OFFLINE_TIME = 9'h16C;
    localparam logic [8:0] OFF_OFFLINE_CAP = 9'h16F;
    localparam logic [8:0] OFF_MONITOR_CAP = 9'h170;
    localparam logic [8:0] OFF_ERRLOG_CAP = 9'h172;
    localparam logic [8:0] OFF_SHORT_TIME = 9'h174;
    localparam logic [8:0] OFF_EXT_TIME = 9'h175;
    localparam logic [7:0] OFFLINE_CAP = 8'h1B;
    localparam logic [15:0] MONITOR_CAP = 16'h0003;
    localparam logic [7:0] ERRLOG_CAP = 8'h01;
    localparam logic [15:0] OFFLINE_TIME_S = 16'h0000;
    localparam logic [7:0] SHORT_TEST_MIN = 8'h01;
    localparam logic [7:0] EXT_TEST_MIN = 8'h01;

    typedef enum logic [2:0] {ST_IDLE, ST_SAVE, ST_CMP, ST_XOUT, ST_XIN, ST_DONE} hlch_state_e;

    typedef struct packed {
        hlch_state_e st;
        logic [7:0] feat;
        logic [7:0] scnt;
        logic [7:0] snum;
        logic [7:0] cyl_lo;
        logic [7:0] cyl_hi;
        logic [7:0] err_reg;
        logic bsy;
        logic drq;
        logic errb;
        logic intrq;
        logic smart_en;
        logic autosave_en;
        logic auto_off;
        logic loaded;
        logic save_req;
        logic cmp_pending;
        logic attr_xfer;
        logic log_valid;
        logic [7:0] log_tag;
        logic [6:0] widx;
        logic [7:0] sum;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic [127:0][31:0] mem;
    } hlch_state_s;
endpackage : hlch_pkg

// ---- logic/hlch_top.sv ----
// Chosen here: the placing of the registers and the APB register port.
`timescale 1ns/1ns
module hlch_top (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic nv_monitor_en,
    input wire logic nv_auto_offline,
    input wire logic threshold_exceeded,
    input wire logic [6:0] offline_code,
    input wire logic [7:0] selftest_status,
    output logic intrq,
    output logic busy,
    output logic monitor_en,
    output logic autosave_en,
    output logic auto_offline_en,
    output logic attr_save_req
);
    hlch_pkg::hlch_state_s r;
    hlch_pkg::hlch_state_s next_r;

    // Attribute entries themselves stay zero here; the attribute store sits outside this block.
    function automatic logic [7:0] attr_byte(input logic [8:0] a, input logic auto_on,
                                             input logic [6:0] ocode, input logic [7:0] ststat);
        logic [7:0] b;
        b = 8'h00;
        case (a)
            9'h000: b = hlch_pkg::ATTR_REVISION[7:0];
            9'h001: b = hlch_pkg::ATTR_REVISION[15:8];
            hlch_pkg::OFF_OFFLINE_STATUS: b = {auto_on, ocode};
            hlch_pkg::OFF_SELFTEST_STATUS: b = ststat;
            hlch_pkg::OFF_OFFLINE_TIME: b = hlch_pkg::OFFLINE_TIME_S[7:0];
            9'h16D: b = hlch_pkg::OFFLINE_TIME_S[15:8];
            hlch_pkg::OFF_OFFLINE_CAP: b = hlch_pkg::OFFLINE_CAP;
            hlch_pkg::OFF_MONITOR_CAP: b = hlch_pkg::MONITOR_CAP[7:0];
            9'h171: b = hlch_pkg::MONITOR_CAP[15:8];
            hlch_pkg::OFF_ERRLOG_CAP: b = hlch_pkg::ERRLOG_CAP;
            hlch_pkg::OFF_SHORT_TIME: b = hlch_pkg::SHORT_TEST_MIN;
            hlch_pkg::OFF_EXT_TIME: b = hlch_pkg::EXT_TEST_MIN;
            default: b = 8'h00;
        endcase
        return b;
    endfunction : attr_byte

    function automatic logic log_writable(input logic [7:0] a);
        return (a == hlch_pkg::LOG_SELECTIVE) || (a >= hlch_pkg::LOG_HOST_FIRST && a <= hlch_pkg::LOG_HOST_LAST);
    endfunction : log_writable

    function automatic logic log_read_only(input logic [7:0] a);
        return (a == hlch_pkg::LOG_DIR) || (a == hlch_pkg::LOG_SUMMARY) || (a == hlch_pkg::LOG_SELFTEST);
    endfunction : log_read_only

    logic access;
    logic [8:0] base;
    logic [7:0] b0;
    logic [7:0] b1;
    logic [7:0] b2;
    logic [7:0] b3;
    logic [31:0] out_word;
    logic cmd_take;

    always_comb begin
        access = psel && penable && !r.pready;
        cmd_take = access && pwrite && paddr == hlch_pkg::ADDR_CMD && r.st == hlch_pkg::ST_IDLE && r.loaded;
        base = {r.widx, 2'b00};
        b0 = attr_byte(base, r.auto_off, offline_code, selftest_status);
        b1 = attr_byte(base + 9'd1, r.auto_off, offline_code, selftest_status);
        b2 = attr_byte(base + 9'd2, r.auto_off, offline_code, selftest_status);
        b3 = attr_byte(base + 9'd3, r.auto_off, offline_code, selftest_status);
        if (r.widx == hlch_pkg::LAST_WORD) begin
            b3 = 8'h00 - (r.sum + b0 + b1 + b2);
        end
        if (r.attr_xfer) begin
            out_word = {b3, b2, b1, b0};
        end else if (r.log_valid && r.log_tag == r.snum && log_writable(r.snum)) begin
            out_word = r.mem[r.widx];
        end else begin
            out_word = 32'h0000_0000;
        end
    end

    always_comb begin
        next_r = r;
        next_r.save_req = 1'b0;
        next_r.pready = 1'b0;
        next_r.pslverr = 1'b0;
        if (!r.loaded) begin
            // Persistent settings come from non-volatile storage once the reset has gone.
            next_r.smart_en = nv_monitor_en;
            next_r.autosave_en = nv_monitor_en;
            next_r.auto_off = nv_auto_offline;
            next_r.loaded = 1'b1;
        end
        if (access) begin
            next_r.pready = 1'b1;
            next_r.prdata = 32'h0000_0000;
            case (paddr)
                hlch_pkg::ADDR_DATA: begin
                    if (!pwrite && r.st == hlch_pkg::ST_XOUT) begin
                        next_r.prdata = out_word;
                        next_r.sum = r.sum + b0 + b1 + b2 + b3;
                        next_r.widx = r.widx + 7'd1;
                        if (r.widx == hlch_pkg::LAST_WORD) begin
                            next_r.st = hlch_pkg::ST_DONE;
                            next_r.drq = 1'b0;
                        end
                    end else if (pwrite && r.st == hlch_pkg::ST_XIN) begin
                        next_r.mem[r.widx] = pwdata;
                        next_r.widx = r.widx + 7'd1;
                        if (r.widx == hlch_pkg::LAST_WORD) begin
                            next_r.log_valid = 1'b1;
                            next_r.st = hlch_pkg::ST_DONE;
                            next_r.drq = 1'b0;
                        end
                    end
                end
                hlch_pkg::ADDR_FEAT: begin
                    if (pwrite && r.st == hlch_pkg::ST_IDLE) begin
                        next_r.feat = pwdata[7:0];
                    end
                    next_r.prdata = {24'h00_0000, r.err_reg};
                end
                hlch_pkg::ADDR_SCNT: begin
                    if (pwrite && r.st == hlch_pkg::ST_IDLE) begin
                        next_r.scnt = pwdata[7:0];
                    end
                    next_r.prdata = {24'h00_0000, r.scnt};
                end
                hlch_pkg::ADDR_SNUM: begin
                    if (pwrite && r.st == hlch_pkg::ST_IDLE) begin
                        next_r.snum = pwdata[7:0];
                    end
                    next_r.prdata = {24'h00_0000, r.snum};
                end
                hlch_pkg::ADDR_CYLLO: begin
                    if (pwrite && r.st == hlch_pkg::ST_IDLE) begin
                        next_r.cyl_lo = pwdata[7:0];
                    end
                    next_r.prdata = {24'h00_0000, r.cyl_lo};
                end
                hlch_pkg::ADDR_CYLHI: begin
                    if (pwrite && r.st == hlch_pkg::ST_IDLE) begin
                        next_r.cyl_hi = pwdata[7:0];
                    end
                    next_r.prdata = {24'h00_0000, r.cyl_hi};
                end
                hlch_pkg::ADDR_CMD: begin
                    next_r.intrq = 1'b0;
                    next_r.prdata = {24'h00_0000, r.bsy, !r.bsy, 3'b000, r.drq, 1'b0, r.errb};
                end
                hlch_pkg::ADDR_CTRL: begin
                    next_r.prdata = {28'h000_0000, r.auto_off, r.autosave_en, r.smart_en, r.intrq};
                end
                default: begin
                    next_r.pslverr = 1'b1;
                end
            endcase
        end
        if (cmd_take) begin
            next_r.bsy = 1'b1;
            next_r.errb = 1'b0;
            next_r.err_reg = 8'h00;
            next_r.widx = 7'h00;
            next_r.sum = 8'h00;
            next_r.attr_xfer = 1'b0;
            next_r.cmp_pending = 1'b0;
            next_r.st = hlch_pkg::ST_DONE;
            if (pwdata[7:0] != hlch_pkg::CMD_MONITOR) begin
                next_r.errb = 1'b1;
            end else if (r.feat == hlch_pkg::SUB_ENABLE) begin
                // Re-enabling only repeats the save; no attribute value is touched.
                next_r.smart_en = 1'b1;
                next_r.autosave_en = 1'b1;
                next_r.st = hlch_pkg::ST_SAVE;
            end else if (!r.smart_en) begin
                next_r.errb = 1'b1;
            end else begin
                case (r.feat)
                    hlch_pkg::SUB_DISABLE: begin
                        next_r.smart_en = 1'b0;
                        next_r.autosave_en = 1'b0;
                        next_r.st = hlch_pkg::ST_SAVE;
                    end
                    hlch_pkg::SUB_STATUS: begin
                        next_r.cmp_pending = 1'b1;
                        next_r.st = hlch_pkg::ST_SAVE;
                    end
                    hlch_pkg::SUB_SAVE_ATTR: begin
                        next_r.st = hlch_pkg::ST_SAVE;
                    end
                    hlch_pkg::SUB_AUTO_OFF: begin
                        if (r.scnt == hlch_pkg::AUTO_OFF_DISABLE) begin
                            next_r.auto_off = 1'b0;
                        end else if (r.scnt == hlch_pkg::AUTO_OFF_ENABLE) begin
                            next_r.auto_off = 1'b1;
                        end else begin
                            next_r.errb = 1'b1;
                        end
                    end
                    hlch_pkg::SUB_READ_ATTR: begin
                        next_r.attr_xfer = 1'b1;
                        next_r.bsy = 1'b0;
                        next_r.drq = 1'b1;
                        next_r.st = hlch_pkg::ST_XOUT;
                    end
                    hlch_pkg::SUB_READ_LOG: begin
                        if (r.scnt != 8'h01 || r.snum == hlch_pkg::LOG_EXT_ERR
                            || r.snum == hlch_pkg::LOG_EXT_SELFTEST) begin
                            next_r.errb = 1'b1;
                        end else if (log_read_only(r.snum) || log_writable(r.snum)) begin
                            next_r.bsy = 1'b0;
                            next_r.drq = 1'b1;
                            next_r.st = hlch_pkg::ST_XOUT;
                        end else begin
                            next_r.errb = 1'b1;
                        end
                    end
                    hlch_pkg::SUB_WRITE_LOG: begin
                        if (r.scnt != 8'h01 || !log_writable(r.snum)) begin
                            next_r.errb = 1'b1;
                        end else begin
                            // Only one writable sector is held; a new write replaces it.
                            next_r.log_tag = r.snum;
                            next_r.log_valid = 1'b0;
                            next_r.bsy = 1'b0;
                            next_r.drq = 1'b1;
                            next_r.st = hlch_pkg::ST_XIN;
                        end
                    end
                    default: begin
                        next_r.errb = 1'b1;
                    end
                endcase
            end
            if (next_r.errb) begin
                next_r.err_reg[hlch_pkg::ABORT_BIT] = 1'b1;
            end
        end
        case (r.st)
            hlch_pkg::ST_SAVE: begin
                next_r.save_req = 1'b1;
                next_r.st = r.cmp_pending ? hlch_pkg::ST_CMP : hlch_pkg::ST_DONE;
            end
            hlch_pkg::ST_CMP: begin
                if (threshold_exceeded) begin
                    next_r.cyl_lo = hlch_pkg::BAD_CYL_LO;
                    next_r.cyl_hi = hlch_pkg::BAD_CYL_HI;
                end else begin
                    next_r.cyl_lo = hlch_pkg::GOOD_CYL_LO;
                    next_r.cyl_hi = hlch_pkg::GOOD_CYL_HI;
                end
                next_r.st = hlch_pkg::ST_DONE;
            end
            hlch_pkg::ST_DONE: begin
                next_r.bsy = 1'b0;
                next_r.intrq = 1'b1;
                next_r.st = hlch_pkg::ST_IDLE;
            end
            default: begin
            end
        endcase
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign prdata = r.prdata;
    assign pready = r.pready;
    assign pslverr = r.pslverr;
    assign intrq = r.intrq;
    assign busy = r.bsy;
    assign monitor_en = r.smart_en;
    assign autosave_en = r.autosave_en;
    // Background collection itself runs outside; this level starts or resumes it.
    assign auto_offline_en = r.auto_off;
    assign attr_save_req = r.save_req;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!resetn);

    sequence s_cmd(logic [7:0] sub);
        cmd_take && pwdata[7:0] == hlch_pkg::CMD_MONITOR && r.feat == sub;
    endsequence

    sequence s_save_then_done;
        r.st == hlch_pkg::ST_SAVE ##1 attr_save_req ##1 intrq && !busy;
    endsequence

    // The compare must never run on values that were not saved first.
    sequence s_save_cmp_done;
        busy && r.st == hlch_pkg::ST_SAVE ##1 attr_save_req && r.st == hlch_pkg::ST_CMP ##1 busy ##1 intrq && !busy;
    endsequence

    a_enable_save_order: assert property (s_cmd(hlch_pkg::SUB_ENABLE) |=> monitor_en ##0 s_save_then_done)
        else $error("enable did not turn on and then save");
    a_disable_all_off: assert property (s_cmd(hlch_pkg::SUB_DISABLE) && monitor_en
        |=> !monitor_en && !autosave_en ##0 s_save_then_done)
        else $error("disable did not clear monitoring and save");
    a_disabled_aborts: assert property (cmd_take && !monitor_en && r.feat != hlch_pkg::SUB_ENABLE
        |=> r.err_reg[hlch_pkg::ABORT_BIT] ##1 intrq && !busy)
        else $error("subcommand accepted while monitoring disabled");
    a_status_good: assert property (s_cmd(hlch_pkg::SUB_STATUS) && monitor_en ##2 !threshold_exceeded
        |=> r.cyl_lo == 8'h4F && r.cyl_hi == 8'hC2)
        else $error("good status signature wrong");
    a_status_bad: assert property (s_cmd(hlch_pkg::SUB_STATUS) && monitor_en ##2 threshold_exceeded
        |=> r.cyl_lo == 8'hF4 && r.cyl_hi == 8'h2C)
        else $error("threshold exceeded signature wrong");
    a_ext_log_abort: assert property (s_cmd(hlch_pkg::SUB_READ_LOG) && monitor_en
        && (r.snum == 8'h03 || r.snum == 8'h07) |=> r.errb && !r.drq)
        else $error("extended log address not aborted");
    a_ro_write_abort: assert property (s_cmd(hlch_pkg::SUB_WRITE_LOG) && monitor_en
        && (r.snum == 8'h00 || r.snum == 8'h01 || r.snum == 8'h06) |=> r.err_reg[hlch_pkg::ABORT_BIT])
        else $error("read-only log write not aborted");
    a_offline_keep: assert property (s_cmd(hlch_pkg::SUB_AUTO_OFF) && monitor_en
        && r.scnt != 8'h00 && r.scnt != 8'hF8 |=> $stable(auto_offline_en) && r.errb)
        else $error("odd count changed automatic off-line setting");
    a_offline_set: assert property (s_cmd(hlch_pkg::SUB_AUTO_OFF) && monitor_en
        && r.scnt == 8'hF8 |=> auto_offline_en ##2 intrq)
        else $error("automatic off-line not enabled");
    a_busy_then_irq: assert property (cmd_take ##1 r.st != hlch_pkg::ST_XOUT && r.st != hlch_pkg::ST_XIN
        |-> busy ##[1:3] (intrq && !busy))
        else $error("busy or interrupt sequence wrong");
    a_status_order: assert property (s_cmd(hlch_pkg::SUB_STATUS) && monitor_en |=> s_save_cmp_done)
        else $error("return status did not save before compare");
    a_idle_no_save: assert property (r.st == hlch_pkg::ST_IDLE && !monitor_en |=> !attr_save_req)
        else $error("attribute save while monitoring off");
    a_offline_clear: assert property (s_cmd(hlch_pkg::SUB_AUTO_OFF) && monitor_en && r.scnt == 8'h00
        |=> !auto_offline_en)
        else $error("automatic off-line not disabled");
    a_log_read_drq: assert property (s_cmd(hlch_pkg::SUB_READ_LOG) && monitor_en && r.scnt == 8'h01
        && r.snum >= 8'h80 && r.snum <= 8'h9F |=> r.drq && !busy && r.st == hlch_pkg::ST_XOUT)
        else $error("host log read did not start transfer");
    a_log_write_drq: assert property (s_cmd(hlch_pkg::SUB_WRITE_LOG) && monitor_en && r.scnt == 8'h01
        && r.snum >= 8'h80 && r.snum <= 8'h9F |=> r.drq && !busy && r.st == hlch_pkg::ST_XIN)
        else $error("host log write did not start transfer");
    a_sector_end: assert property (r.drq && r.widx == hlch_pkg::LAST_WORD
        && access && paddr == hlch_pkg::ADDR_DATA
        && pwrite == (r.st == hlch_pkg::ST_XIN) |=> !r.drq ##1 intrq)
        else $error("transfer did not end after 512 bytes");
    a_sum_zero: assert property (r.attr_xfer && r.st == hlch_pkg::ST_XOUT && r.widx == hlch_pkg::LAST_WORD
        && access && paddr == hlch_pkg::ADDR_DATA && !pwrite |=> r.sum == 8'h00)
        else $error("structure bytes do not sum to zero");
endmodule : hlch_top

// ---- dv/hlch_host.sv ----
`timescale 1ns/1ns
module hlch_host (
    input wire logic mclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic pready
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
    end
    // The request is held until pready is seen or 20 clocks pass, so no fixed wait state count is assumed.
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic to);
        int n;
        to = 1'b1;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge mclk);
            if (pready === 1'b1) begin
                to = 1'b0;
                break;
            end
        end
        psel <= 1'b0;
        penable <= 1'b0;
        // Released data lines must not keep showing the old word.
        pwdata <= ~d;
    endtask : xfer
endmodule : hlch_host

// ---- dv/test_health_log_command_handler.sv ----
`timescale 1ns/1ns
module test_health_log_command_handler;
    typedef struct {logic [31:0] m; logic [31:0] e; logic er;} hlch_note_s;
    hlch_note_s q[$];
    hlch_note_s nt;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, intrq, busy, mon, ase, aoe, asr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic nvm = 1'b0;
    logic nva = 1'b0;
    logic thr = 1'b0;
    logic [6:0] ocode = 7'h00;
    logic [7:0] sts = 8'h00;
    logic acc = 1'b0;
    logic [7:0] bsum;
    logic [31:0] lb [128];
    int errors = 0;
    int cmp_count = 0;
    int saves = 0;
    int exp_saves = 0;
    always #25 mclk = ~mclk;
    always @(posedge mclk) if (asr === 1'b1) saves++;
    hlch_host host (.mclk(mclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready));
    hlch_top DUT (.mclk(mclk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .nv_monitor_en(nvm), .nv_auto_offline(nva), .threshold_exceeded(thr), .offline_code(ocode),
        .selftest_status(sts), .intrq(intrq), .busy(busy), .monitor_en(mon), .autosave_en(ase),
        .auto_offline_en(aoe), .attr_save_req(asr));
    task report_and_stop;
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : report_and_stop
    task cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp
    always @(posedge mclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            nt = q.pop_front();
            cmp("prdata", nt.e & nt.m, prdata & nt.m);
            cmp("pslverr", {31'h0, nt.er}, {31'h0, pslverr});
            if (acc) bsum = bsum + prdata[7:0] + prdata[15:8] + prdata[23:16] + prdata[31:24];
        end
    end
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        logic to;
        host.xfer(w, a, d, to);
        if (to) begin
            errors++;
            report_and_stop;
        end
    endtask : bus
    task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        q.push_back('{m, e, (a > hlch_pkg::ADDR_CTRL)});
        bus(1'b0, a, 32'h0000_0000);
    endtask : rd
    task cmd(input logic [7:0] f, input logic [7:0] s, input logic [7:0] n);
        bus(1'b1, hlch_pkg::ADDR_FEAT, {24'h0, f});
        bus(1'b1, hlch_pkg::ADDR_SCNT, {24'h0, s});
        bus(1'b1, hlch_pkg::ADDR_SNUM, {24'h0, n});
        bus(1'b1, hlch_pkg::ADDR_CMD, {24'h0, hlch_pkg::CMD_MONITOR});
    endtask : cmd
    task fin(input logic er, input logic sv);
        int n;
        for (n = 0; n < 40 && intrq !== 1'b1; n++) @(posedge mclk);
        if (n == 40) begin
            errors++;
            report_and_stop;
        end
        rd(hlch_pkg::ADDR_CMD, {24'h0, 2'b01, 5'h00, er}, 32'h0000_00C1);
        @(posedge mclk);
        cmp("intrq", 32'h0, {31'h0, intrq});
        cmp("busy", 32'h0, {31'h0, busy});
        exp_saves += sv;
        cmp("attr_save_req", exp_saves, saves);
    endtask : fin
    task ctrl(input logic [31:0] e, input logic [31:0] m);
        rd(hlch_pkg::ADDR_CTRL, e, m);
        cmp("pins", e & m & 32'h0000_000E, {28'h0, aoe, ase, mon, 1'b0} & m & 32'h0000_000E);
    endtask : ctrl
    initial begin
        int i;
        logic [7:0] a;
        void'($urandom(63));
        repeat (16) @(posedge mclk);
        resetn <= 1'b1;
        repeat (2) @(posedge mclk);
        ctrl(32'h0, 32'h0000_000E);
        cmd(hlch_pkg::SUB_READ_LOG, 8'h01, 8'h00);
        fin(1'b1, 1'b0);
        rd(hlch_pkg::ADDR_FEAT, 32'h0000_0004, 32'h0000_0004);
        $display("test disabled done");
        for (i = 0; i < 2; i++) begin
            cmd(hlch_pkg::SUB_ENABLE, 8'h00, 8'h00);
            fin(1'b0, 1'b1);
            ctrl(32'h0000_0006, 32'h0000_0006);
        end
        bus(1'b1, hlch_pkg::ADDR_CMD, 32'h0000_00EC);
        fin(1'b1, 1'b0);
        cmd(hlch_pkg::SUB_SAVE_ATTR, 8'h00, 8'h00);
        fin(1'b0, 1'b1);
        for (i = 0; i < 2; i++) begin
            thr <= i[0];
            cmd(hlch_pkg::SUB_STATUS, 8'h00, 8'h00);
            fin(1'b0, 1'b1);
            rd(hlch_pkg::ADDR_CYLLO, i ? 32'h0000_00F4 : 32'h0000_004F, 32'h0000_00FF);
            rd(hlch_pkg::ADDR_CYLHI, i ? 32'h0000_002C : 32'h0000_00C2, 32'h0000_00FF);
        end
        cmd(hlch_pkg::SUB_AUTO_OFF, hlch_pkg::AUTO_OFF_ENABLE, 8'h00);
        fin(1'b0, 1'b0);
        ctrl(32'h0000_0008, 32'h0000_0008);
        cmd(hlch_pkg::SUB_AUTO_OFF, 8'($urandom_range(1, 247)), 8'h00);
        fin(1'b1, 1'b0);
        ctrl(32'h0000_0008, 32'h0000_0008);
        cmd(hlch_pkg::SUB_AUTO_OFF, hlch_pkg::AUTO_OFF_DISABLE, 8'h00);
        fin(1'b0, 1'b0);
        ctrl(32'h0, 32'h0000_0008);
        $display("test status done");
        for (i = 0; i < 5; i++) begin
            a = i < 2 ? (i ? 8'h07 : 8'h03) : (i == 2 ? 8'h00 : (i == 3 ? 8'h01 : 8'h06));
            cmd(i < 2 ? hlch_pkg::SUB_READ_LOG : hlch_pkg::SUB_WRITE_LOG, 8'h01, a);
            fin(1'b1, 1'b0);
        end
        cmd(hlch_pkg::SUB_READ_LOG, 8'h02, hlch_pkg::LOG_SELECTIVE);
        fin(1'b1, 1'b0);
        cmd(hlch_pkg::SUB_WRITE_LOG, 8'h02, hlch_pkg::LOG_HOST_FIRST);
        fin(1'b1, 1'b0);
        a = 8'h80 + 8'($urandom_range(0, 31));
        cmd(hlch_pkg::SUB_WRITE_LOG, 8'h01, a);
        for (i = 0; i < 128; i++) begin
            lb[i] = $urandom;
            bus(1'b1, hlch_pkg::ADDR_DATA, lb[i]);
        end
        fin(1'b0, 1'b0);
        cmd(hlch_pkg::SUB_READ_LOG, 8'h01, a);
        for (i = 0; i < 128; i++) rd(hlch_pkg::ADDR_DATA, lb[i], 32'hFFFF_FFFF);
        fin(1'b0, 1'b0);
        $display("test logs done");
        ocode <= 7'($urandom);
        sts <= 8'($urandom);
        cmd(hlch_pkg::SUB_READ_ATTR, 8'h00, 8'h00);
        bsum = 8'h00;
        acc = 1'b1;
        for (i = 0; i < 128; i++) begin
            case (i)
                0: rd(hlch_pkg::ADDR_DATA, 32'h0000_0010, 32'hFFFF_FFFF);
                90: rd(hlch_pkg::ADDR_DATA, {sts, 1'b0, ocode, 16'h0}, 32'hFFFF_0000);
                91: rd(hlch_pkg::ADDR_DATA, 32'h1B00_0000, 32'hFF00_FFFF);
                92: rd(hlch_pkg::ADDR_DATA, 32'h0001_0003, 32'h00FF_FFFF);
                93: rd(hlch_pkg::ADDR_DATA, 32'h0000_0101, 32'h0000_FFFF);
                default: rd(hlch_pkg::ADDR_DATA, 32'h0, i == 127 ? 32'h00FF_FFFF : 32'hFFFF_FFFF);
            endcase
        end
        // The watcher adds the last word at the edge the read ends, so stop summing one edge later.
        @(posedge mclk);
        acc = 1'b0;
        cmp("checksum", 32'h0, {24'h0, bsum});
        fin(1'b0, 1'b0);
        $display("test structure done");
        cmd(hlch_pkg::SUB_DISABLE, 8'h00, 8'h00);
        fin(1'b0, 1'b1);
        ctrl(32'h0, 32'h0000_0006);
        cmd(hlch_pkg::SUB_DISABLE, 8'h00, 8'h00);
        fin(1'b1, 1'b0);
        cmd(hlch_pkg::SUB_SAVE_ATTR, 8'h00, 8'h00);
        fin(1'b1, 1'b0);
        rd(8'h20, 32'h0, 32'h0);
        $display("test disable done");
        nvm <= 1'b1;
        nva <= 1'b1;
        resetn <= 1'b0;
        repeat (2) @(posedge mclk);
        resetn <= 1'b1;
        repeat (2) @(posedge mclk);
        ctrl(32'h0000_000E, 32'h0000_000E);
        $display("test persistence done");
        report_and_stop;
    end
endmodule : test_health_log_command_handler
